// File: logic/tcw_pkg.sv
package tcw_pkg;

    localparam int          CNT_W  = 16;
    localparam int          DIV_W  = 10;
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // Byte addresses of the channel registers.
    localparam logic [7:0]  OFS_CTRL = 8'h00;
    localparam logic [7:0]  OFS_MODE = 8'h04;
    localparam logic [7:0]  OFS_CV   = 8'h10;
    localparam logic [7:0]  OFS_RA   = 8'h14;
    localparam logic [7:0]  OFS_RB   = 8'h18;
    localparam logic [7:0]  OFS_RC   = 8'h1C;
    localparam logic [7:0]  OFS_STAT = 8'h20;

    // Command bits of the control register and status bit positions.
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_DIS_BIT = 1;
    localparam int          CTRL_SWT_BIT = 2;
    localparam int          STAT_CLK_BIT = 16;
    localparam int          STAT_A_BIT   = 17;
    localparam int          STAT_B_BIT   = 18;

    // Internal clock taps: divide by 2, 8, 32, 128 and 1024.
    localparam logic [DIV_W-1:0] TAP_MASK [5] =
        '{10'h001, 10'h007, 10'h01F, 10'h07F, 10'h3FF};
    localparam logic [2:0]  CLK_INT_LAST = 3'h4;

    localparam logic [1:0]  EDGE_RISE = 2'h1;
    localparam logic [1:0]  EDGE_FALL = 2'h2;
    localparam logic [1:0]  EDGE_BOTH = 2'h3;
    localparam logic [1:0]  ACT_NONE  = 2'h0;
    localparam logic [1:0]  ACT_SET   = 2'h1;
    localparam logic [1:0]  ACT_CLR   = 2'h2;
    localparam logic [1:0]  ACT_TOG   = 2'h3;
    localparam logic [1:0]  SRC_LINE_B = 2'h0;

    localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;
    localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
    localparam logic [DIV_W-1:0]  DIV_ONE  = 10'h001;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    // Mode register as seen in waveform mode.
    typedef struct packed {
        logic [1:0] line_b_on_soft_trigger;
        logic [1:0] line_b_on_event;
        logic [1:0] line_b_on_limit_match;
        logic [1:0] line_b_on_second_match;
        logic [1:0] line_a_on_soft_trigger;
        logic [1:0] line_a_on_event;
        logic [1:0] line_a_on_limit_match;
        logic [1:0] line_a_on_first_match;
        logic       wave;
        logic [1:0] count_shape_sel;
        logic       event_restart_enable;
        logic [1:0] event_source_sel;
        logic [1:0] event_edge_sel;
        logic       disable_on_limit;
        logic       stop_on_limit;
        logic [1:0] gate_sel;
        logic       count_edge_invert;
        logic [2:0] count_clock_source;
    } tcw_wave_cfg_t;

    // Mode register as seen in capture mode.
    typedef struct packed {
        logic [11:0] unused_hi;
        logic [1:0]  second_load_edge;
        logic [1:0]  first_load_edge;
        logic        wave;
        logic        limit_match_restart;
        logic [2:0]  unused_mid;
        logic        trigger_line_sel;
        logic [1:0]  trigger_edge_sel;
        logic        disable_on_second_load;
        logic        stop_on_second_load;
        logic [1:0]  gate_sel;
        logic        count_edge_invert;
        logic [2:0]  count_clock_source;
    } tcw_capt_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] mode;
        logic [CNT_W-1:0]  count_now;
        logic [CNT_W-1:0]  capture_reg_first;
        logic [CNT_W-1:0]  capture_reg_second;
        logic [CNT_W-1:0]  limit_reg;
        logic [DIV_W-1:0]  div;
        logic              count_down;
        logic              clk_on;
        logic              clk_stopped;
        logic              line_a;
        logic              line_b;
        logic              line_a_oe;
        logic              line_b_oe;
        logic              prev_a;
        logic              prev_b;
        logic [2:0]        prev_x;
        logic              ack;
        logic              wait_q;
        logic [DATA_W-1:0] rdata;
    } tcw_state_t;

    // True when the selected edge kind is seen between two samples.
    function automatic logic tcw_edge_hit(input logic [1:0] sel,
                                          input logic       cur,
                                          input logic       prev);
        tcw_edge_hit = ((sel == EDGE_RISE) && cur && !prev) ||
                       ((sel == EDGE_FALL) && !cur && prev) ||
                       ((sel == EDGE_BOTH) && (cur != prev));
    endfunction : tcw_edge_hit

    // Applies one set, clear or toggle action to a line level.
    function automatic logic tcw_apply(input logic [1:0] act,
                                       input logic       v);
        case (act)
            ACT_SET: tcw_apply = 1'b1;
            ACT_CLR: tcw_apply = 1'b0;
            ACT_TOG: tcw_apply = !v;
            default: tcw_apply = v;
        endcase
    endfunction : tcw_apply

endpackage : tcw_pkg

// File: logic/tcw_channel.sv
module tcw_channel
    import tcw_pkg::*;
(
    input  wire logic              SYS_CLK_I,
    input  wire logic              SRST_I,
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic              AVS_READ_I,
    input  wire logic              AVS_WRITE_I,
    input  wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]        AVS_BYTEENABLE_I,
    output logic      [DATA_W-1:0] AVS_READDATA_O,
    output logic                   AVS_WAITREQUEST_O,
    input  wire logic              LINE_A_I,
    output logic                   LINE_A_O,
    output logic                   LINE_A_OE_O,
    input  wire logic              LINE_B_I,
    output logic                   LINE_B_O,
    output logic                   LINE_B_OE_O,
    input  wire logic [2:0]        EXT_CLK_I
);

    tcw_state_t    s_reg;
    tcw_state_t    s_next;
    tcw_wave_cfg_t wv;
    tcw_capt_cfg_t cp;
    logic          tick_p;
    logic          restart_p;
    logic          soft_p;
    logic          lim_p;
    logic          ld_a_p;

    // Both views overlay the same mode word.
    assign wv = tcw_wave_cfg_t'(s_reg.mode);
    assign cp = tcw_capt_cfg_t'(s_reg.mode);

    // Outputs come straight from the state flops.
    assign AVS_READDATA_O    = s_reg.rdata;
    assign AVS_WAITREQUEST_O = s_reg.wait_q;
    assign LINE_A_O          = s_reg.line_a;
    assign LINE_A_OE_O       = s_reg.line_a_oe;
    assign LINE_B_O          = s_reg.line_b;
    assign LINE_B_OE_O       = s_reg.line_b_oe;

    // All next-state logic of the channel. Bus writes are applied at
    // the edge where waitrequest is seen low, so they line up with the
    // master's own notion of completion.
    always_comb begin
        logic              req;
        logic              wr_go;
        logic [DATA_W-1:0] wmask;
        logic [DATA_W-1:0] wd;
        logic [1:0]        xi;
        logic [1:0]        gi;
        logic              src_edge;
        logic              gate;
        logic              trg_cur;
        logic              trg_prev;
        logic              ext_trig;
        logic              ev_cur;
        logic              ev_prev;
        logic              ev;
        logic              first_m;
        logic              second_m;
        logic              ld_b;
        logic              auto_hit;
        logic [1:0]        act_a;
        logic [1:0]        act_b;
        logic [DATA_W-1:0] rd;
        tcw_wave_cfg_t     nw;
        req      = AVS_READ_I || AVS_WRITE_I;
        wr_go    = AVS_WRITE_I && s_reg.ack;
        wmask    = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
        wd       = AVS_WRITEDATA_I & wmask;
        xi       = 2'(wv.count_clock_source[1:0] - 2'h1);
        gi       = 2'(wv.gate_sel - 2'h1);
        src_edge = 1'b0;
        gate     = 1'b1;
        ext_trig = 1'b0;
        trg_cur  = 1'b0;
        trg_prev = 1'b0;
        ev_cur   = 1'b0;
        ev_prev  = 1'b0;
        nw       = wv;
        ev       = 1'b0;
        first_m  = 1'b0;
        second_m = 1'b0;
        ld_b     = 1'b0;
        auto_hit = 1'b0;
        act_a    = ACT_NONE;
        act_b    = ACT_NONE;
        rd       = WORD_ZERO;
        restart_p = 1'b0;
        ld_a_p    = 1'b0;
        s_next   = s_reg;
        s_next.div    = DIV_W'(s_reg.div + DIV_ONE);
        s_next.prev_a = LINE_A_I;
        s_next.prev_b = LINE_B_I;
        s_next.prev_x = EXT_CLK_I;

        // Counting clock: a divider tap, or an edge of an external
        // clock. Internal taps are already one-cycle pulses, so the
        // invert bit has no visible effect on them.
        if (wv.count_clock_source <= CLK_INT_LAST) begin
            src_edge = (s_reg.div & TAP_MASK[wv.count_clock_source])
                       == TAP_MASK[wv.count_clock_source];
        end else if (wv.count_edge_invert) begin
            src_edge = !EXT_CLK_I[xi] && s_reg.prev_x[xi];
        end else begin
            src_edge = EXT_CLK_I[xi] && !s_reg.prev_x[xi];
        end
        if (wv.gate_sel != 2'h0) begin
            gate = EXT_CLK_I[gi];
        end
        tick_p = src_edge && gate && s_reg.clk_on && !s_reg.clk_stopped;
        lim_p  = tick_p && (s_reg.count_now == s_reg.limit_reg);

        // Control register: enable, disable and software trigger.
        soft_p = wr_go && (AVS_ADDRESS_I == OFS_CTRL)
                 && wd[CTRL_SWT_BIT];

        if (!wv.wave) begin
            // Capture mode.
            trg_cur  = cp.trigger_line_sel ? LINE_A_I : LINE_B_I;
            trg_prev = cp.trigger_line_sel ? s_reg.prev_a : s_reg.prev_b;
            ext_trig = tcw_edge_hit(cp.trigger_edge_sel,
                                    trg_cur, trg_prev);
            ld_a_p   = tcw_edge_hit(cp.first_load_edge,
                                    LINE_A_I, s_reg.prev_a);
            ld_b     = tcw_edge_hit(cp.second_load_edge,
                                    LINE_A_I, s_reg.prev_a);
            if (ld_a_p) begin
                s_next.capture_reg_first = s_reg.count_now;
            end
            if (ld_b) begin
                s_next.capture_reg_second = s_reg.count_now;
                s_next.clk_stopped = s_reg.clk_stopped
                                     || cp.stop_on_second_load;
                s_next.clk_on = s_reg.clk_on
                                && !cp.disable_on_second_load;
            end
            restart_p = soft_p || ext_trig
                        || (cp.limit_match_restart && lim_p);
            if (tick_p) begin
                s_next.count_now = CNT_W'(s_reg.count_now + CNT_ONE);
            end
        end else begin
            // Waveform mode: event source and edge.
            if (wv.event_source_sel == SRC_LINE_B) begin
                ev_cur  = LINE_B_I;
                ev_prev = s_reg.prev_b;
            end else begin
                ev_cur  = EXT_CLK_I[2'(wv.event_source_sel - 2'h1)];
                ev_prev = s_reg.prev_x[2'(wv.event_source_sel - 2'h1)];
            end
            ev = tcw_edge_hit(wv.event_edge_sel, ev_cur, ev_prev);
            first_m  = tick_p
                       && (s_reg.count_now == s_reg.capture_reg_first);
            second_m = tick_p
                       && (s_reg.count_now == s_reg.capture_reg_second);
            auto_hit = wv.count_shape_sel[1] && lim_p;
            restart_p = soft_p || (wv.event_restart_enable && ev)
                        || (auto_hit && !wv.count_shape_sel[0]);
            if (tick_p) begin
                if (!s_reg.count_down) begin
                    if (wv.count_shape_sel[0]
                        && ((s_reg.count_now == CNT_MAX) || auto_hit)) begin
                        s_next.count_down = 1'b1;
                        s_next.count_now  = CNT_W'(s_reg.count_now - CNT_ONE);
                    end else begin
                        s_next.count_now  = CNT_W'(s_reg.count_now + CNT_ONE);
                    end
                end else if (s_reg.count_now == CNT_ZERO) begin
                    s_next.count_down = 1'b0;
                    s_next.count_now  = CNT_ONE;
                end else begin
                    s_next.count_now  = CNT_W'(s_reg.count_now - CNT_ONE);
                end
            end
            if (lim_p && wv.stop_on_limit) begin
                s_next.clk_stopped = 1'b1;
            end
            if (lim_p && wv.disable_on_limit) begin
                s_next.clk_on = 1'b0;
            end

            // One action per line: soft trigger, then event, then
            // limit match, then register match. A soft trigger or event whose
            // field says none lets the next source through; a limit match never does.
            if (soft_p && (wv.line_a_on_soft_trigger != ACT_NONE)) begin
                act_a = wv.line_a_on_soft_trigger;
            end else if (ev && (wv.line_a_on_event != ACT_NONE)) begin
                act_a = wv.line_a_on_event;
            end else if (lim_p) begin
                act_a = wv.line_a_on_limit_match;
            end else if (first_m) begin
                act_a = wv.line_a_on_first_match;
            end
            if (soft_p && (wv.line_b_on_soft_trigger != ACT_NONE)) begin
                act_b = wv.line_b_on_soft_trigger;
            end else if (ev && (wv.line_b_on_event != ACT_NONE)) begin
                act_b = wv.line_b_on_event;
            end else if (lim_p) begin
                act_b = wv.line_b_on_limit_match;
            end else if (second_m) begin
                act_b = wv.line_b_on_second_match;
            end
            s_next.line_a = tcw_apply(act_a, s_reg.line_a);
            s_next.line_b = tcw_apply(act_b, s_reg.line_b);
        end

        // A trigger resets the count and restarts a stopped clock; it
        // cannot revive a clock that software or the limit disabled.
        if (restart_p) begin
            s_next.count_now   = CNT_ZERO;
            s_next.count_down  = 1'b0;
            s_next.clk_stopped = 1'b0;
        end

        // Bus writes. Hardware loads of the capture registers win over
        // a write landing in the same cycle.
        if (wr_go) begin
            case (AVS_ADDRESS_I)
                OFS_CTRL: begin
                    if (wd[CTRL_DIS_BIT]) begin
                        s_next.clk_on = 1'b0;
                    end else if (wd[CTRL_EN_BIT]) begin
                        s_next.clk_on      = 1'b1;
                        s_next.clk_stopped = 1'b0;
                    end
                end
                OFS_MODE: begin
                    s_next.mode = (s_reg.mode & ~wmask) | wd;
                end
                OFS_RA: begin
                    if (wv.wave) begin
                        s_next.capture_reg_first = CNT_W'(wd);
                    end
                end
                OFS_RB: begin
                    if (wv.wave) begin
                        s_next.capture_reg_second = CNT_W'(wd);
                    end
                end
                OFS_RC: begin
                    s_next.limit_reg = CNT_W'(wd);
                end
                default: begin
                end
            endcase
        end

        // Line directions follow the mode word that will be in force.
        // Reading the fields by name keeps the directions tied to the
        // struct layout if the mode word is ever rearranged.
        nw = tcw_wave_cfg_t'(s_next.mode);
        s_next.line_a_oe = nw.wave;
        s_next.line_b_oe = nw.wave
            && (nw.event_source_sel != SRC_LINE_B);

        // Read mux, sampled on the first cycle of a request so that the
        // data already stand when waitrequest drops.
        case (AVS_ADDRESS_I)
            OFS_MODE: rd = s_reg.mode;
            OFS_CV:   rd = DATA_W'(s_reg.count_now);
            OFS_RA:   rd = DATA_W'(s_reg.capture_reg_first);
            OFS_RB:   rd = DATA_W'(s_reg.capture_reg_second);
            OFS_RC:   rd = DATA_W'(s_reg.limit_reg);
            OFS_STAT: begin
                rd[STAT_CLK_BIT] = s_reg.clk_on && !s_reg.clk_stopped;
                rd[STAT_A_BIT]   = wv.wave ? s_reg.line_a : LINE_A_I;
                rd[STAT_B_BIT]   = s_reg.line_b_oe ? s_reg.line_b
                                                   : LINE_B_I;
            end
            default:  rd = WORD_ZERO;
        endcase
        s_next.ack    = req && !s_reg.ack;
        s_next.wait_q = !(req && !s_reg.ack);
        if (AVS_READ_I && !s_reg.ack) begin
            s_next.rdata = rd;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            s_reg        <= '0;
            s_reg.wait_q <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SRST_I);

    chk_soft_restart: assert property (soft_p |=>
        s_reg.count_now == CNT_ZERO && !s_reg.clk_stopped)
        else $error("software trigger did not restart the counter");

    chk_limit_restart: assert property (
        (!wv.wave && cp.limit_match_restart && lim_p)
        |=> s_reg.count_now == CNT_ZERO)
        else $error("limit match did not restart in capture mode");

    chk_stop_limit: assert property (
        (wv.wave && wv.stop_on_limit && lim_p && !restart_p
         && !(AVS_WRITE_I && !AVS_WAITREQUEST_O
              && AVS_ADDRESS_I == OFS_CTRL))
        |=> s_reg.clk_stopped && !tick_p)
        else $error("clock kept running after stop on limit");

    chk_dis_limit: assert property (
        (wv.wave && wv.disable_on_limit && lim_p && !soft_p
         && !(AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_WRITEDATA_I[0]
              && AVS_ADDRESS_I == OFS_CTRL))
        |=> !s_reg.clk_on)
        else $error("clock not disabled at limit match");

    chk_line_a_dir: assert property (!wv.wave |-> !LINE_A_OE_O)
        else $error("line A driven in capture mode");

    chk_line_b_dir: assert property (
        (wv.event_source_sel == SRC_LINE_B) |-> !LINE_B_OE_O)
        else $error("line B driven while it is the event input");

    chk_soft_set_a: assert property (
        (wv.wave && soft_p && wv.line_a_on_soft_trigger == ACT_SET)
        |=> LINE_A_O)
        else $error("software trigger did not set line A");

    chk_soft_clr_b: assert property (
        (wv.wave && soft_p && wv.event_source_sel != SRC_LINE_B
         && wv.line_b_on_soft_trigger == ACT_CLR)
        |=> !LINE_B_O)
        else $error("software trigger did not clear line B");

    chk_cv_read: assert property (
        (AVS_READ_I && AVS_ADDRESS_I == OFS_CV && AVS_WAITREQUEST_O)
        |=> !AVS_WAITREQUEST_O
            && AVS_READDATA_O == DATA_W'($past(s_reg.count_now)))
        else $error("counter read did not return the live count");

    chk_ra_locked: assert property (
        (!wv.wave && !ld_a_p && AVS_WRITE_I && !AVS_WAITREQUEST_O
         && AVS_ADDRESS_I == OFS_RA)
        |=> $stable(s_reg.capture_reg_first))
        else $error("first register written in capture mode");

    chk_up_wrap: assert property (
        (wv.wave && wv.count_shape_sel == 2'h0 && tick_p && !restart_p)
        |=> s_reg.count_now == CNT_W'($past(s_reg.count_now) + CNT_ONE))
        else $error("up counter did not step by one");

endmodule : tcw_channel

// File: testbench/tcw_pin_model.sv
module tcw_pin_model (
    input  wire logic       clk_i,
    input  wire logic       burst_i,
    input  wire logic       a_oe_i,
    input  wire logic       a_drv_i,
    input  wire logic       b_oe_i,
    input  wire logic       b_drv_i,
    output logic            a_pin_o,
    output logic            b_pin_o,
    output logic [2:0]      ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    // Undriven pins sit at the pull-up level, so a stale value never shows.
    assign a_pin_o = a_oe_i ? a_drv_i : 1'b1;
    assign b_pin_o = b_oe_i ? b_drv_i : 1'b1;
    // A burst is five pulses on clock zero; it stands low outside bursts.
    always @(posedge clk_i) begin
        if (burst_i) begin
            left <= 20;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign ext_clk_o = {2'b00, (left > 0) && left[1]};
endmodule : tcw_pin_model

// File: testbench/timer_channel_mode_waveform_tb.sv
module timer_channel_mode_waveform_tb
    import tcw_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, q, lfsr = 32'h0000_F5B1;
    logic        wt, a_o, a_oe, b_o, b_oe, a_pin, b_pin, burst = 1'b0;
    logic [2:0]  xc;
    logic        a_m = 1'b0, b_m = 1'b0;
    logic [1:0]  acts [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3};
    int          miscompares = 0, total_checks = 0;
    tcw_channel uut (.SYS_CLK_I(clk), .SRST_I(rst), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wt), .LINE_A_I(a_pin), .LINE_A_O(a_o),
        .LINE_A_OE_O(a_oe), .LINE_B_I(b_pin), .LINE_B_O(b_o),
        .LINE_B_OE_O(b_oe), .EXT_CLK_I(xc));
    tcw_pin_model pins (.clk_i(clk), .burst_i(burst), .a_oe_i(a_oe),
        .a_drv_i(a_o), .b_oe_i(b_oe), .b_drv_i(b_o), .a_pin_o(a_pin),
        .b_pin_o(b_pin), .ext_clk_o(xc));
    // Free-running 50 MHz system clock.
    initial begin
        forever #10 clk = !clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One bus access; the request is held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
    endtask : bus
    // Own model of a set, clear or toggle action on a line level.
    function automatic logic act(input logic [1:0] c, input logic v);
        return (c == 2'h1) ? 1'b1 : (c == 2'h2) ? 1'b0 : (c == 2'h3) ? !v : v;
    endfunction : act
    // One step of the bench's 32-bit shift register random source.
    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_step
    // Program a mode, enable and trigger, then let one burst run out.
    task automatic pulses(input logic [31:0] m);
        bus(1'b1, OFS_MODE, m);
        bus(1'b1, OFS_CTRL, 32'h0000_0005);
        burst <= 1'b1;
        @(posedge clk);
        burst <= 1'b0;
        repeat (30) @(posedge clk);
    endtask : pulses
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values, two unmapped places, and line A not driven in capture.
        foreach (acts[i]) begin
            bus(1'b0, (i == 4) ? 8'h08 : OFS_MODE + 8'(i * 8), 32'h0);
            chk(q, 32'h0000_0000);
        end
        lfsr = lfsr_step(lfsr);
        bus(1'b1, OFS_RA, lfsr);
        bus(1'b1, OFS_CV, lfsr);
        bus(1'b0, OFS_RA, 32'h0);
        chk(q, 32'h0000_0000);
        bus(1'b0, OFS_CV, 32'h0);
        chk(q, 32'h0000_0000);
        chk(a_oe, 1'b0);
        $display("capture test done");
        // Waveform mode; line B as event source turns it into an input.
        bus(1'b1, OFS_MODE, 32'h0000_8000);
        repeat (3) @(posedge clk);
        chk({a_oe, b_oe}, 2'b10);
        bus(1'b1, OFS_MODE, 32'h0000_8400);
        bus(1'b1, OFS_RA, lfsr);
        bus(1'b0, OFS_RA, 32'h0);
        chk(q, {16'h0000, lfsr[15:0]});
        chk(b_oe, 1'b1);
        // Every soft-trigger action code on both lines.
        foreach (acts[i]) begin
            bus(1'b1, OFS_MODE,
                32'h0000_8400 | {acts[i], 6'h0, acts[i], 22'h0});
            bus(1'b1, OFS_CTRL, 32'h0000_0004);
            repeat (3) @(posedge clk);
            a_m = act(acts[i], a_m);
            b_m = act(acts[i], b_m);
            chk(a_o, a_m);
            chk(b_o, b_m);
        end
        $display("soft trigger test done");
        // External clock zero counts five rising edges.
        pulses(32'h0000_8405);
        bus(1'b0, OFS_CV, 32'h0);
        chk(q, 32'h0000_0005);
        // Disable on limit: the clock is off after the count meets two.
        bus(1'b1, OFS_RC, 32'h0000_0002);
        pulses(32'h0000_8485);
        bus(1'b0, OFS_STAT, 32'h0);
        chk(q[STAT_CLK_BIT], 1'b0);
        // Stop on limit: a software trigger restarts a stopped clock.
        pulses(32'h0000_8445);
        bus(1'b0, OFS_STAT, 32'h0);
        chk(q[STAT_CLK_BIT], 1'b0);
        bus(1'b1, OFS_CTRL, 32'h0000_0004);
        bus(1'b0, OFS_STAT, 32'h0);
        chk(q[STAT_CLK_BIT], 1'b1);
        // Capture mode: a limit match of two restarts the count.
        pulses(32'h0000_4005);
        bus(1'b0, OFS_CV, 32'h0);
        chk(q, 32'h0000_0002);
        $display("counting test done");
        end_of_test();
    end
endmodule : timer_channel_mode_waveform_tb
